/* File: sac_consts.svh */
// constants for the switch port admission control block
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register map, byte offsets inside a port's window
`define SAC_PORT_STRIDE 8'h10
`define SAC_OFS_CTRL 4'h0
`define SAC_OFS_RATE 4'h4
`define SAC_OFS_STAT 4'h8

// control register fields
`define SAC_CTRL_EN 0
`define SAC_CTRL_AUTO 1
`define SAC_CTRL_SPD_LO 2
`define SAC_CTRL_SPD_HI 3
`define SAC_CTRL_DUP 4
`define SAC_CTRL_FC 5
`define SAC_CTRL_SEC 6
`define SAC_CTRL_STORM 7
`define SAC_CTRL_JUMBO 8
`define SAC_CTRL_RST 9'h1b7

// rate register fields
`define SAC_RATE_IN_LO 0
`define SAC_RATE_IN_HI 12
`define SAC_RATE_EG_LO 16
`define SAC_RATE_EG_HI 28
`define SAC_RATE_MAX 13'h1f40

// frame lengths in bytes
`define SAC_MAX_STD 14'h05ee
`define SAC_MAX_JUMBO 14'h2400

// timing: credit is kept in half rate-units per clock
`define SAC_CLK_HZ 25000000
`define SAC_RATE_UNIT_BPS 128000
`define SAC_BYTE_COST ((2 * 8 * `SAC_CLK_HZ) / `SAC_RATE_UNIT_BPS)
`define SAC_BURST_CREDIT (`SAC_BYTE_COST * 9216)

`endif

/* File: sac_pkg.sv */
// types shared by the port admission control files
package sac_pkg;
	typedef enum logic [1:0] {
		SAC_BUS_IDLE = 2'b01,
		SAC_BUS_HOLD = 2'b10
	} sac_bus_st_t;
endpackage

/* File: sac_rate_meter.sv */
// token bucket that meters bytes against a 128 kbit/s step rate
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_rate_meter #(
	parameter int RATE_W = 13,
	parameter int CRED_W = 32
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// rate and usage
	input wire logic [RATE_W-1:0] rate_i,
	input wire logic byte_i,
	output logic ok_o
);
	typedef struct packed {
		logic signed [CRED_W-1:0] credit;
	} sac_meter_t;

	localparam logic signed [CRED_W-1:0] FULL = CRED_W'(`SAC_BURST_CREDIT);
	localparam logic signed [CRED_W-1:0] COST = CRED_W'(`SAC_BYTE_COST);
	localparam logic signed [CRED_W-1:0] ZERO = CRED_W'(0);

	sac_meter_t st;
	sac_meter_t nx;
	logic signed [CRED_W-1:0] gain;

	assign gain = {{(CRED_W-RATE_W-1){1'b0}}, rate_i, 1'b0};

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nx = st;
		if (rate_i == '0) begin
			nx.credit = FULL;
		end else begin
			nx.credit = st.credit + gain - (byte_i ? COST : ZERO);
			// bounded both ways so a long overload cannot wrap
			if (nx.credit > FULL) begin
				nx.credit = FULL;
			end else if (nx.credit < -FULL) begin
				nx.credit = -FULL;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st.credit <= FULL;
		end else begin
			st <= nx;
		end
	end

	assign ok_o = (rate_i == '0) || !st.credit[CRED_W-1];
endmodule

/* File: sac_frame_gate.sv */
// per-port frame verdict: length, lock, storm and overload checks
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_frame_gate #(
	parameter int LEN_W = 14
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// port settings
	input wire logic port_en_i,
	input wire logic jumbo_en_i,
	input wire logic secure_i,
	input wire logic storm_block_i,
	input wire logic overload_drop_i,
	// received byte stream
	input wire logic valid_i,
	input wire logic sop_i,
	input wire logic eop_i,
	input wire logic src_known_i,
	input wire logic bcast_i,
	// verdict pulses
	output logic fwd_o,
	output logic drop_o
);
	typedef struct packed {
		logic [LEN_W-1:0] len;
		logic bad;
		logic fwd;
		logic drop;
	} sac_gate_t;

	sac_gate_t st;
	sac_gate_t nx;
	logic [LEN_W-1:0] len_n;
	logic [LEN_W-1:0] limit;
	logic bad_n;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nx = st;
		nx.fwd = 1'b0;
		nx.drop = 1'b0;
		limit = jumbo_en_i ? LEN_W'(`SAC_MAX_JUMBO) : LEN_W'(`SAC_MAX_STD);
		len_n = sop_i ? LEN_W'(1) : st.len;
		bad_n = sop_i ? 1'b0 : st.bad;
		if (!sop_i && st.len != '1) begin
			len_n = st.len + LEN_W'(1);
		end
		if (!port_en_i) begin
			bad_n = 1'b1;
		end
		if (overload_drop_i) begin
			bad_n = 1'b1;
		end
		if (storm_block_i && bcast_i) begin
			bad_n = 1'b1;
		end
		if (secure_i && !src_known_i) begin
			bad_n = 1'b1;
		end
		if (len_n > limit) begin
			bad_n = 1'b1;
		end
		if (valid_i) begin
			nx.len = len_n;
			nx.bad = bad_n;
			if (eop_i) begin
				nx.fwd = !bad_n;
				nx.drop = bad_n;
				nx.len = '0;
				nx.bad = 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign fwd_o = st.fwd;
	assign drop_o = st.drop;

	////////////////////////////////////////////////////////////////////////
	AST_LONG_STD_DROP: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		(valid_i && eop_i && !sop_i && !jumbo_en_i
		&& st.len >= LEN_W'(`SAC_MAX_STD)) |=> (drop_o && !fwd_o))
		else $error("overlong frame not dropped");

	AST_JUMBO_PASS: assert property (@(posedge clock_i)
		disable iff (sys_rst_i)
		(valid_i && eop_i && !sop_i && jumbo_en_i && port_en_i
		&& !overload_drop_i && !secure_i && !storm_block_i
		&& st.len < LEN_W'(`SAC_MAX_JUMBO) && !st.bad) |=> fwd_o)
		else $error("jumbo frame not forwarded");
endmodule

/* File: sac_port_admit.sv */
// switch port admission control: registers, link mode, limits, verdicts
`timescale 1ns/10ps
`include "sac_consts.svh"
module sac_port_admit #(
	parameter int NUM_PORTS = 10
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic sys_rst_i,
	// register bus
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// negotiation results
	input wire logic [NUM_PORTS-1:0][1:0] an_speed_i,
	input wire logic [NUM_PORTS-1:0] an_duplex_i,
	// receive side
	input wire logic [NUM_PORTS-1:0] rx_valid_i,
	input wire logic [NUM_PORTS-1:0] rx_sop_i,
	input wire logic [NUM_PORTS-1:0] rx_eop_i,
	input wire logic [NUM_PORTS-1:0] rx_src_known_i,
	input wire logic [NUM_PORTS-1:0] rx_bcast_i,
	input wire logic [NUM_PORTS-1:0] rx_overload_i,
	input wire logic storm_active_i,
	// receive verdicts and feedback
	output logic [NUM_PORTS-1:0] rx_fwd_o,
	output logic [NUM_PORTS-1:0] rx_drop_o,
	output logic [NUM_PORTS-1:0] learn_en_o,
	output logic [NUM_PORTS-1:0] pause_req_o,
	output logic [NUM_PORTS-1:0] backpressure_o,
	// transmit side
	input wire logic [NUM_PORTS-1:0] tx_req_i,
	output logic [NUM_PORTS-1:0] tx_ok_o,
	// effective link settings
	output logic [NUM_PORTS-1:0] port_en_o,
	output logic [NUM_PORTS-1:0][1:0] speed_o,
	output logic [NUM_PORTS-1:0] duplex_o
);
	typedef struct packed {
		sac_pkg::sac_bus_st_t bus;
		logic [31:0] rdata;
		logic [NUM_PORTS-1:0][8:0] ctrl;
		logic [NUM_PORTS-1:0][12:0] in_rate;
		logic [NUM_PORTS-1:0][12:0] eg_rate;
		logic [NUM_PORTS-1:0][1:0] speed;
		logic [NUM_PORTS-1:0] duplex;
		logic [NUM_PORTS-1:0] pause;
		logic [NUM_PORTS-1:0] bp;
		logic [NUM_PORTS-1:0] learn;
	} sac_state_t;

	localparam logic [4:0] NP = 5'(NUM_PORTS);
	localparam sac_state_t ST_RST = '{
		bus: sac_pkg::SAC_BUS_IDLE,
		rdata: 32'h0,
		ctrl: {NUM_PORTS{`SAC_CTRL_RST}},
		in_rate: '0,
		eg_rate: '0,
		speed: '0,
		duplex: '0,
		pause: '0,
		bp: '0,
		learn: '0
	};

	sac_state_t st;
	sac_state_t nx;
	logic [3:0] port_idx;
	logic [3:0] pi;
	logic hit;
	logic [31:0] rd_val;
	logic [31:0] wr_word;
	logic [NUM_PORTS-1:0] in_ok;
	logic [NUM_PORTS-1:0] eg_ok;
	logic [NUM_PORTS-1:0] ovl_drop;

	////////////////////////////////////////////////////////////////////////
	// byte-lane merge of a write into the old word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0] be
	);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				res[8*b +: 8] = wd[8*b +: 8];
			end
		end
		return res;
	endfunction

	// out-of-range rates are held at the top of the range
	function automatic logic [12:0] rate_clamp(input logic [12:0] r);
		return (r > `SAC_RATE_MAX) ? `SAC_RATE_MAX : r;
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign port_idx = avs_address_i[7:4];
	assign hit = ({1'b0, port_idx} < NP);
	assign pi = hit ? port_idx : 4'h0;

	always_comb begin
		rd_val = 32'h0;
		if (hit) begin
			unique case (avs_address_i[3:0])
				`SAC_OFS_CTRL: begin
					rd_val = {23'h0, st.ctrl[pi]};
				end
				`SAC_OFS_RATE: begin
					rd_val = {3'h0, st.eg_rate[pi], 3'h0, st.in_rate[pi]};
				end
				`SAC_OFS_STAT: begin
					rd_val = {25'h0, eg_ok[pi], in_ok[pi], st.bp[pi],
						st.pause[pi], st.duplex[pi], st.speed[pi]};
				end
				default: begin
					rd_val = 32'h0;
				end
			endcase
		end
	end

	// reads wait one cycle so read data leave a register
	assign avs_waitrequest_o = avs_read_i && (st.bus == sac_pkg::SAC_BUS_IDLE);
	assign avs_readdata_o = st.rdata;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		nx = st;
		wr_word = 32'h0;
		unique case (st.bus)
			sac_pkg::SAC_BUS_IDLE: begin
				if (avs_read_i) begin
					nx.bus = sac_pkg::SAC_BUS_HOLD;
					nx.rdata = rd_val;
				end else if (avs_write_i && hit) begin
					if (avs_address_i[3:0] == `SAC_OFS_CTRL) begin
						wr_word = lane_merge({23'h0, st.ctrl[pi]},
							avs_writedata_i, avs_byteenable_i);
						// manual speed and duplex frozen when the merged write word has automatic set
						if (wr_word[`SAC_CTRL_AUTO]) begin
							wr_word[`SAC_CTRL_SPD_HI:`SAC_CTRL_SPD_LO] =
								st.ctrl[pi][`SAC_CTRL_SPD_HI:`SAC_CTRL_SPD_LO];
							wr_word[`SAC_CTRL_DUP] = st.ctrl[pi][`SAC_CTRL_DUP];
						end
						nx.ctrl[pi] = wr_word[8:0];
					end else if (avs_address_i[3:0] == `SAC_OFS_RATE) begin
						wr_word = lane_merge(
							{3'h0, st.eg_rate[pi], 3'h0, st.in_rate[pi]},
							avs_writedata_i, avs_byteenable_i);
						nx.in_rate[pi] = rate_clamp(
							wr_word[`SAC_RATE_IN_HI:`SAC_RATE_IN_LO]);
						nx.eg_rate[pi] = rate_clamp(
							wr_word[`SAC_RATE_EG_HI:`SAC_RATE_EG_LO]);
					end
				end
			end
			sac_pkg::SAC_BUS_HOLD: begin
				nx.bus = sac_pkg::SAC_BUS_IDLE;
			end
		endcase
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (st.ctrl[p][`SAC_CTRL_AUTO]) begin
				nx.speed[p] = an_speed_i[p];
				nx.duplex[p] = an_duplex_i[p];
			end else begin
				nx.speed[p] = st.ctrl[p][`SAC_CTRL_SPD_HI:`SAC_CTRL_SPD_LO];
				nx.duplex[p] = st.ctrl[p][`SAC_CTRL_DUP];
			end
			// pause only with flow control on and full duplex
			nx.pause[p] = st.ctrl[p][`SAC_CTRL_EN]
				&& st.ctrl[p][`SAC_CTRL_FC] && st.duplex[p]
				&& (rx_overload_i[p] || !in_ok[p]);
			nx.bp[p] = st.ctrl[p][`SAC_CTRL_EN] && !st.duplex[p]
				&& (!in_ok[p]
				|| (st.ctrl[p][`SAC_CTRL_FC] && rx_overload_i[p]));
			nx.learn[p] = st.ctrl[p][`SAC_CTRL_EN]
				&& !st.ctrl[p][`SAC_CTRL_SEC];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st <= ST_RST;
		end else begin
			st <= nx;
		end
	end

	////////////////////////////////////////////////////////////////////////
	generate
		for (genvar g = 0; g < NUM_PORTS; g++) begin : g_port
			assign port_en_o[g] = st.ctrl[g][`SAC_CTRL_EN];
			assign speed_o[g] = st.speed[g];
			assign duplex_o[g] = st.duplex[g];
			assign pause_req_o[g] = st.pause[g];
			assign backpressure_o[g] = st.bp[g];
			assign learn_en_o[g] = st.learn[g];
			assign tx_ok_o[g] = st.ctrl[g][`SAC_CTRL_EN] && eg_ok[g];
			// no pause allowed here, so overload, and over-limit ingress in full duplex, is dropped
			assign ovl_drop[g] = !st.ctrl[g][`SAC_CTRL_FC]
				&& (rx_overload_i[g] || (!in_ok[g] && st.duplex[g]));

			sac_rate_meter #(
				.RATE_W(13),
				.CRED_W(32)
			) u_in_meter (
				.clock_i(clock_i),
				.sys_rst_i(sys_rst_i),
				.rate_i(st.in_rate[g]),
				.byte_i(rx_valid_i[g] && st.ctrl[g][`SAC_CTRL_EN]),
				.ok_o(in_ok[g])
			);

			sac_rate_meter #(
				.RATE_W(13),
				.CRED_W(32)
			) u_eg_meter (
				.clock_i(clock_i),
				.sys_rst_i(sys_rst_i),
				.rate_i(st.eg_rate[g]),
				.byte_i(tx_req_i[g] && tx_ok_o[g]),
				.ok_o(eg_ok[g])
			);

			sac_frame_gate #(
				.LEN_W(14)
			) u_gate (
				.clock_i(clock_i),
				.sys_rst_i(sys_rst_i),
				.port_en_i(st.ctrl[g][`SAC_CTRL_EN]),
				.jumbo_en_i(st.ctrl[g][`SAC_CTRL_JUMBO]),
				.secure_i(st.ctrl[g][`SAC_CTRL_SEC]),
				.storm_block_i(st.ctrl[g][`SAC_CTRL_STORM] && storm_active_i),
				.overload_drop_i(ovl_drop[g]),
				.valid_i(rx_valid_i[g]),
				.sop_i(rx_sop_i[g]),
				.eop_i(rx_eop_i[g]),
				.src_known_i(rx_src_known_i[g]),
				.bcast_i(rx_bcast_i[g]),
				.fwd_o(rx_fwd_o[g]),
				.drop_o(rx_drop_o[g])
			);

			////////////////////////////////////////////////////////////////
			AST_DIS_NO_TX: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				!st.ctrl[g][`SAC_CTRL_EN] |-> !tx_ok_o[g])
				else $error("disabled port may transmit");

			AST_DIS_NO_RX: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(rx_valid_i[g] && rx_eop_i[g] && !st.ctrl[g][`SAC_CTRL_EN])
				|=> (rx_drop_o[g] && !rx_fwd_o[g]))
				else $error("disabled port forwarded a frame");

			AST_AUTO_LINK: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				st.ctrl[g][`SAC_CTRL_AUTO] |=>
				(speed_o[g] == $past(an_speed_i[g])
				&& duplex_o[g] == $past(an_duplex_i[g])))
				else $error("automatic mode ignores negotiation");

			AST_FORCED_LINK: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				!st.ctrl[g][`SAC_CTRL_AUTO] |=>
				(speed_o[g] == $past(st.ctrl[g][3:2])
				&& duplex_o[g] == $past(st.ctrl[g][`SAC_CTRL_DUP])))
				else $error("forced mode ignores configuration");

			AST_AUTO_RO: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
				&& avs_writedata_i[`SAC_CTRL_AUTO]
				&& avs_address_i == 8'(g * 16) + 8'(`SAC_OFS_CTRL))
				|=> $stable(st.ctrl[g][4:2]))
				else $error("speed or duplex written in automatic mode");

			AST_FC_PAUSE: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(st.ctrl[g][`SAC_CTRL_EN] && st.ctrl[g][`SAC_CTRL_FC]
				&& st.duplex[g] && rx_overload_i[g]) |=> pause_req_o[g])
				else $error("no pause on overload");

			AST_NOFC_QUIET: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				!st.ctrl[g][`SAC_CTRL_FC] |=> !pause_req_o[g])
				else $error("pause with flow control off");

			AST_NOFC_DROP: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(!st.ctrl[g][`SAC_CTRL_FC] && rx_overload_i[g]
				&& rx_valid_i[g] && rx_eop_i[g]) |=> rx_drop_o[g])
				else $error("overload frame not dropped");

			AST_RATE_RANGE: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				st.in_rate[g] <= `SAC_RATE_MAX
				&& st.eg_rate[g] <= `SAC_RATE_MAX)
				else $error("rate limit out of range");

			AST_LIMIT_HOLD: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(st.ctrl[g][`SAC_CTRL_EN] && !in_ok[g]
				&& (!st.duplex[g] || st.ctrl[g][`SAC_CTRL_FC]))
				|=> (pause_req_o[g] || backpressure_o[g]))
				else $error("ingress over limit not held back");

			AST_LOCK: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(st.ctrl[g][`SAC_CTRL_SEC] && rx_valid_i[g] && rx_eop_i[g]
				&& !rx_src_known_i[g]) |=> (rx_drop_o[g] && !learn_en_o[g]))
				else $error("locked port passed unknown source");

			AST_STORM: assert property (@(posedge clock_i)
				disable iff (sys_rst_i)
				(st.ctrl[g][`SAC_CTRL_STORM] && storm_active_i
				&& rx_bcast_i[g] && rx_valid_i[g] && rx_eop_i[g])
				|=> rx_drop_o[g])
				else $error("storm filter passed broadcast");
		end
	endgenerate
endmodule

/* File: sac_link_partner.sv */
// remote link partner: sends one frame at a time, halts while paused
`timescale 1ns/10ps
module sac_link_partner #(
	parameter int N = 10
) (
	// clock
	input wire logic clock_i,
	// frame request from the bench
	input wire logic go_i,
	input wire logic [3:0] port_i,
	input wire logic [13:0] len_i,
	// pause feedback from the switch
	input wire logic [N-1:0] pause_i,
	// byte stream into the switch
	output logic [N-1:0] valid_o,
	output logic [N-1:0] sop_o,
	output logic [N-1:0] eop_o,
	output logic busy_o
);
	int cnt;
	initial begin
		valid_o = '0;
		sop_o = '0;
		eop_o = '0;
		busy_o = 1'b0;
		cnt = 0;
	end
	// strobes fall between frames so a stale byte is never reused
	always @(posedge clock_i) begin
		valid_o <= '0;
		sop_o <= '0;
		eop_o <= '0;
		if (go_i && !busy_o) begin
			busy_o <= 1'b1;
			cnt <= 0;
		end else if (busy_o && !pause_i[port_i]) begin
			valid_o[port_i] <= 1'b1;
			sop_o[port_i] <= (cnt == 0);
			eop_o[port_i] <= (cnt == int'(len_i) - 1);
			cnt <= cnt + 1;
			if (cnt == int'(len_i) - 1)
				busy_o <= 1'b0;
		end
	end
endmodule

/* File: tb_top.sv */
// self-checking bench for the port admission control block
`timescale 1ns/10ps
`include "sac_consts.svh"
module tb_top;
	logic clock_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [7:0] addr = 8'h00;
	logic rd = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic wreq;
	logic [9:0][1:0] an_speed = '0;
	logic [9:0] an_dup = '1;
	logic [9:0] vld, sop, eop, pause, bp, fwd, drop, learn, tx_ok, pen, dup;
	logic [9:0][1:0] spd;
	logic [9:0] known = '1;
	logic [9:0] bcast = '0;
	logic [9:0] ovl = '0;
	logic [9:0] tx_req = '0;
	logic storm = 1'b0;
	logic f_go = 1'b0;
	logic [3:0] f_port = 4'h0;
	logic [13:0] f_len = 14'h0040;
	logic busy;
	logic [31:0] got;
	int fails = 0;
	int n_checks = 0;

	always #20 clock_i = ~clock_i;

	sac_port_admit #(.NUM_PORTS(10)) DUT (.clock_i(clock_i),
		.sys_rst_i(sys_rst_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr_en), .avs_writedata_i(wdata),
		.avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wreq), .an_speed_i(an_speed),
		.an_duplex_i(an_dup), .rx_valid_i(vld), .rx_sop_i(sop),
		.rx_eop_i(eop), .rx_src_known_i(known), .rx_bcast_i(bcast),
		.rx_overload_i(ovl), .storm_active_i(storm), .rx_fwd_o(fwd),
		.rx_drop_o(drop), .learn_en_o(learn), .pause_req_o(pause),
		.backpressure_o(bp), .tx_req_i(tx_req), .tx_ok_o(tx_ok),
		.port_en_o(pen), .speed_o(spd), .duplex_o(dup));

	sac_link_partner #(.N(10)) peer (.clock_i(clock_i), .go_i(f_go),
		.port_i(f_port), .len_i(f_len), .pause_i(pause), .valid_o(vld),
		.sop_o(sop), .eop_o(eop), .busy_o(busy));

	////////////////////////////////////////////////////////////////
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("mismatch at %0t: got %h exp %h", $time, s, e);
		end
	endtask

	task automatic tmo();
		fails++;
		$display("mismatch at %0t: wait ran out", $time);
		results();
	endtask

	// bus cycle: held until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int i;
		logic ws;
		@(posedge clock_i);
		addr <= a;
		wdata <= d;
		wr_en <= w;
		rd <= !w;
		// sampled mid-cycle: these are the values the next edge sees
		for (i = 0; i < 50; i++) begin
			@(negedge clock_i);
			ws = wreq;
			got = rdata;
			@(posedge clock_i);
			if (ws === 1'b0)
				break;
		end
		wr_en <= 1'b0;
		rd <= 1'b0;
		if (i == 50)
			tmo();
	endtask

	task automatic frame(input int p, input int len);
		int i;
		@(posedge clock_i);
		f_port <= p[3:0];
		f_len <= len[13:0];
		f_go <= 1'b1;
		@(posedge clock_i);
		f_go <= 1'b0;
		for (i = 0; i < 20000; i++) begin
			@(negedge clock_i);
			if ((fwd[p] | drop[p]) === 1'b1)
				break;
		end
		// forwarded gives 2'b10, dropped 2'b01
		got = {30'h0, fwd[p], drop[p]};
		if (i == 20000)
			tmo();
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		bus(0, 8'h00, 0);
		chk(got, `SAC_CTRL_RST);
		bus(0, 8'h94, 0);
		chk(got, 0);
		bus(0, 8'hc0, 0);
		chk(got, 0);
		bus(0, 8'h0c, 0);
		chk(got, 0);
		// 13-bit fields: 8191 is the largest value written, the clamp holds it at 8000
		bus(1, 8'h94, 32'h1fff_1fff);
		bus(0, 8'h94, 0);
		chk(got, 32'h1f40_1f40);
		bus(1, 8'h94, 0);
	endtask

	task automatic t_link();
		an_speed[0] <= 2'h1;
		an_dup[0] <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(spd[0], 2'h1);
		chk(dup[0], 0);
		bus(1, 8'h00, 32'h1bb);
		bus(0, 8'h00, 0);
		chk(got, `SAC_CTRL_RST);
		bus(1, 8'h00, 32'h1a9);
		bus(0, 8'h00, 0);
		chk(got, 32'h1a9);
		repeat (2) @(posedge clock_i);
		chk(spd[0], 2'h2);
		chk(dup[0], 0);
		an_dup[0] <= 1'b1;
	endtask

	task automatic t_frames();
		bus(1, 8'h10, 32'h0b7);
		frame(1, 1519);
		chk(got, 1);
		frame(1, 1518);
		chk(got, 2);
		bus(1, 8'h10, `SAC_CTRL_RST);
		frame(1, 1519);
		chk(got, 2);
		chk(learn[1], 1);
		bus(1, 8'h60, 32'h1f7);
		// learn enable is registered behind the control bit
		repeat (2) @(negedge clock_i);
		chk(learn[6], 0);
		known[6] <= 1'b0;
		frame(6, 64);
		chk(got, 1);
		known[6] <= 1'b1;
		frame(6, 1);
		chk(got, 2);
		storm <= 1'b1;
		bcast[7] <= 1'b1;
		frame(7, 64);
		chk(got, 1);
		bus(1, 8'h70, 32'h137);
		frame(7, 64);
		chk(got, 2);
		storm <= 1'b0;
	endtask

	task automatic t_flow();
		bus(1, 8'h40, 32'h197);
		ovl[4] <= 1'b1;
		frame(4, 64);
		chk(got, 1);
		chk(pause[4], 0);
		bus(1, 8'h40, `SAC_CTRL_RST);
		repeat (3) @(posedge clock_i);
		chk(pause[4], 1);
		ovl[4] <= 1'b0;
		repeat (3) @(posedge clock_i);
		chk(pause[4], 0);
	endtask

	task automatic t_ingress();
		// forced half duplex, flow control on, one-step ingress limit
		bus(1, 8'h30, 32'h1a5);
		bus(1, 8'h34, 32'h0000_0001);
		// one full burst passes, the next frame runs out of credit
		frame(3, 9216);
		chk(got, 2);
		frame(3, 64);
		chk(got, 2);
		chk(bp[3], 1);
		chk(pause[3], 0);
		bus(0, 8'h38, 0);
		chk(got, 32'h0000_0051);
		bus(1, 8'h34, 0);
		repeat (2) @(negedge clock_i);
		chk(bp[3], 0);
	endtask

	task automatic t_disable();
		tx_req[5] <= 1'b1;
		repeat (2) @(posedge clock_i);
		chk(tx_ok[5], 1);
		bus(1, 8'h50, 32'h1b6);
		repeat (2) @(posedge clock_i);
		chk(pen[5], 0);
		chk(tx_ok[5], 0);
		frame(5, 64);
		chk(got, 1);
		tx_req[5] <= 1'b0;
	endtask

	task automatic t_egress();
		int i;
		tx_req[2] <= 1'b1;
		bus(1, 8'h24, 32'h0001_0000);
		for (i = 0; i < 12000; i++) begin
			@(negedge clock_i);
			if (tx_ok[2] === 1'b0)
				break;
		end
		if (i == 12000)
			tmo();
		chk(tx_ok[2], 0);
		bus(1, 8'h24, 0);
		repeat (2) @(posedge clock_i);
		chk(tx_ok[2], 1);
		tx_req[2] <= 1'b0;
	endtask

	initial begin
		repeat (20) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_link();
		t_frames();
		t_flow();
		t_disable();
		t_ingress();
		t_egress();
		results();
	end
endmodule
